// >>> logic/dmib_pkg.sv
/*
 * Shared constants, field layout and carrier types of the mode-register
 * information and burst-order block.
 * Assumes one core clock and a slower link clock from the controller that
 * the core clock samples.
 */
`default_nettype none
package dmib_pkg;
   // ==========================================================
   // Mode register addresses
   localparam logic [7:0] MR_INFO_ADDR = 8'h00;
   localparam logic [7:0] MR_FEAT_ADDR = 8'h01;
   localparam logic [7:0] MR_CALIB_ADDR = 8'h0a;

   // ==========================================================
   // Information register field positions
   localparam int INFO_INIT_BIT = 0;
   localparam int INFO_CLASS_BIT = 1;
   localparam int INFO_DNV_BIT = 2;
   localparam int INFO_ZQ_LSB = 3;
   localparam logic INFO_CLASS_VALUE = 1'b0;
   localparam logic INFO_DNV_VALUE = 1'b0;

   // ==========================================================
   // Feature register field positions and reset value
   localparam int FEAT_BL_LSB = 0;
   localparam int FEAT_BT_BIT = 3;
   localparam int FEAT_WC_BIT = 4;
   localparam int FEAT_WR_LSB = 5;
   localparam logic [7:0] FEAT_RESET = 8'h22;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_16 = 3'h4;
   localparam logic [3:0] WR_CODE_OFFSET = 4'h2;

   // ==========================================================
   // Self-test result codes
   localparam logic [1:0] ZQ_NOT_SUPPORTED = 2'h0;
   localparam logic [1:0] ZQ_TIED_SUPPLY = 2'h1;
   localparam logic [1:0] ZQ_SHORT_GND = 2'h2;
   localparam logic [1:0] ZQ_PASS = 2'h3;

   // ==========================================================
   // Cycle counts
   localparam int INIT_CYCLES_DEF = 64;
   localparam int ZQ_CAL_CYCLES_DEF = 32;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // ==========================================================
   // Command codes and the sampled command/address word
   typedef enum logic [2:0] {
      DMIB_CMD_NOP = 3'h0,
      DMIB_CMD_MRW = 3'h1,
      DMIB_CMD_MRR = 3'h2,
      DMIB_CMD_WRITE = 3'h3,
      DMIB_CMD_READ = 3'h4
   } dmib_cmd_t;

   typedef struct packed {
      logic [2:0] cmd;
      logic auto_pre;
      logic [7:0] addr;
      logic [7:0] data;
      logic [8:1] col;
   } dmib_ca_word_t;
endpackage
`default_nettype wire

// >>> logic/dmib_burst_seq.sv
/*
 * Burst column sequencer: emits one column offset per core clock for each
 * beat of a burst, in wrap/no-wrap, sequential/interleaved order.
 * Assumes the caller only starts it while busy is low.
 */
`timescale 1ns/100ps
`default_nettype none
module dmib_burst_seq #(
   parameter int COL_W = 9
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Burst request
   input wire logic start,
   input wire logic [COL_W-1:0] start_col,
   input wire logic [2:0] len_code,
   input wire logic interleave,
   input wire logic no_wrap,
   // Beat stream
   output logic [COL_W-1:0] beat_col,
   output logic beat_valid,
   output logic beat_last,
   output logic busy
);
   import dmib_pkg::*;

   typedef enum logic [1:0] {
      DMIB_BS_IDLE = 2'b01,
      DMIB_BS_RUN = 2'b10
   } dmib_bs_state_t;

   dmib_bs_state_t state, next_state;
   logic [3:0] beat_idx, next_beat_idx;
   logic [3:0] mask, next_mask;
   logic [COL_W-1:0] base, next_base;
   logic ilv, next_ilv, nw, next_nw;
   logic [COL_W-1:0] next_beat_col;
   logic next_beat_valid, next_beat_last, next_busy;
   logic [COL_W-1:0] wide_mask, wide_idx, col_now;

   // ==========================================================
   // Column of the current beat
   assign wide_mask = {{(COL_W-4){1'b0}}, mask};
   assign wide_idx = {{(COL_W-4){1'b0}}, beat_idx};
   always_comb begin
      if (nw) begin
         col_now = base + wide_idx;
      end else if (ilv) begin
         col_now = (base & ~wide_mask) | ((base ^ wide_idx) & wide_mask);
      end else begin
         col_now = (base & ~wide_mask) | ((base + wide_idx) & wide_mask);
      end
   end

   // ==========================================================
   // Sequencer next state; unknown length codes fall back to four beats
   always_comb begin
      next_state = state;
      next_beat_idx = beat_idx;
      next_mask = mask;
      next_base = base;
      next_ilv = ilv;
      next_nw = nw;
      next_beat_col = beat_col;
      next_beat_valid = 1'b0;
      next_beat_last = 1'b0;
      next_busy = busy;
      unique case (state)
         DMIB_BS_IDLE: begin
            if (start) begin
               next_state = DMIB_BS_RUN;
               next_beat_idx = 4'h0;
               next_base = start_col;
               next_ilv = interleave;
               next_nw = no_wrap;
               next_busy = 1'b1;
               case (len_code)
                  BL_CODE_8: next_mask = 4'h7;
                  BL_CODE_16: next_mask = 4'hf;
                  default: next_mask = 4'h3;
               endcase
            end
         end
         DMIB_BS_RUN: begin
            next_beat_col = col_now;
            next_beat_valid = 1'b1;
            next_beat_idx = beat_idx + 4'h1;
            if (beat_idx == mask) begin
               next_beat_last = 1'b1;
               next_state = DMIB_BS_IDLE;
               next_busy = 1'b0;
            end
         end
      endcase
   end

   // Registers only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= DMIB_BS_IDLE;
         beat_idx <= 4'h0;
         mask <= 4'h3;
         base <= '0;
         ilv <= 1'b0;
         nw <= 1'b0;
         beat_col <= '0;
         beat_valid <= 1'b0;
         beat_last <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         beat_idx <= next_beat_idx;
         mask <= next_mask;
         base <= next_base;
         ilv <= next_ilv;
         nw <= next_nw;
         beat_col <= next_beat_col;
         beat_valid <= next_beat_valid;
         beat_last <= next_beat_last;
         busy <= next_busy;
      end
   end
endmodule
`default_nettype wire

// >>> logic/dmib_top.sv
/*
 * Device-side mode register information and burst ordering logic: samples
 * the controller's link clock and command/address pins, answers mode
 * register reads, holds the feature register, runs the calibration
 * self-test and drives burst column order and write-recovery precharge.
 * Assumes the controller holds each command word steady for a whole link
 * clock period, which is far longer than the core clock period.
 */
`timescale 1ns/100ps
`default_nettype none
// Function
// - Bit0 shows initialization still running
// - Class and invalid-data bits read zero
// - Bits 4:3 encode calibration pin self-test
// - Self-test result updates after calibration completes
// - Pin tied to supply reports 01
// - Fault result: factory trim, ignore calibration
// - Bits 7:5 set write-recovery cycles
// - Lowest bit of the burst start column always zero
// - Writes to information register ignored
// - Reserved bits read back zero
module dmib_top #(
   parameter int INIT_CYCLES = dmib_pkg::INIT_CYCLES_DEF,
   parameter int ZQ_CAL_CYCLES = dmib_pkg::ZQ_CAL_CYCLES_DEF,
   parameter bit ZQ_SELFTEST_EN = 1'b1
) (
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Link pins from the controller
   input wire logic link_clk,
   input wire dmib_pkg::dmib_ca_word_t ca_pins,
   // Analog sense of the calibration pin: 00 resistor, 01 supply/float, 10 ground
   input wire logic [1:0] zq_sense,
   // Mode register read answer
   output logic [7:0] mr_rd_data,
   output logic mr_rd_valid,
   // Burst column stream
   output logic [8:0] beat_col,
   output logic beat_valid,
   output logic beat_is_write,
   // Precharge and impedance control
   output logic auto_precharge_start,
   output logic factory_trim_active,
   output logic calib_apply
);
   import dmib_pkg::*;

   typedef enum logic [1:0] {
      DMIB_PRE_IDLE = 2'b01,
      DMIB_PRE_WAIT = 2'b10
   } dmib_pre_state_t;

   // ==========================================================
   // Input synchronisers
   logic link_m, link_s, link_d;
   dmib_ca_word_t ca_m, ca_s;
   logic [1:0] zq_m, zq_s;
   logic link_rise;

   // Two stages per pin; the first stage feeds only the second.
   // Link stages reset high so a link clock already high at release is no edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         link_m <= 1'b1;
         link_s <= 1'b1;
         link_d <= 1'b1;
         ca_m <= '0;
         ca_s <= '0;
         zq_m <= 2'h0;
         zq_s <= 2'h0;
      end else begin
         link_m <= link_clk;
         link_s <= link_m;
         link_d <= link_s;
         ca_m <= ca_pins;
         ca_s <= ca_m;
         zq_m <= zq_sense;
         zq_s <= zq_m;
      end
   end

   // Word and clock share the same latency, so the word is settled at the edge
   assign link_rise = link_s & ~link_d;

   // ==========================================================
   // Command decode
   logic is_mrw, is_mrr, is_burst;
   assign is_mrw = link_rise && (ca_s.cmd == DMIB_CMD_MRW);
   assign is_mrr = link_rise && (ca_s.cmd == DMIB_CMD_MRR);
   assign is_burst = link_rise && ((ca_s.cmd == DMIB_CMD_WRITE) || (ca_s.cmd == DMIB_CMD_READ));

   // ==========================================================
   // Initialization, calibration and feature register state
   logic [15:0] init_cnt, next_init_cnt;
   logic [15:0] zq_cnt, next_zq_cnt;
   logic [1:0] zq_result, next_zq_result;
   logic next_factory_trim_active, next_calib_apply;
   logic [7:0] feat, next_feat;
   logic [1:0] zq_mapped;
   logic [7:0] info;

   // Map the pin sense to a result code; a supply-tied pin reads 01
   always_comb begin
      unique case (zq_s)
         2'h1: zq_mapped = ZQ_TIED_SUPPLY;
         2'h2: zq_mapped = ZQ_SHORT_GND;
         2'h3: zq_mapped = ZQ_TIED_SUPPLY;
         default: zq_mapped = ZQ_PASS;
      endcase
   end

   // Next values of the control state
   always_comb begin
      next_init_cnt = init_cnt;
      next_zq_cnt = zq_cnt;
      next_zq_result = zq_result;
      next_factory_trim_active = factory_trim_active;
      next_calib_apply = 1'b0;
      next_feat = feat;
      if (init_cnt != CNT_ZERO) begin
         next_init_cnt = init_cnt - CNT_ONE;
      end
      // Calibration only starts when not locked out and idle
      if (is_mrw && (ca_s.addr == MR_CALIB_ADDR) && !factory_trim_active && (zq_cnt == CNT_ZERO)) begin
         next_zq_cnt = 16'(ZQ_CAL_CYCLES);
      end else if (zq_cnt != CNT_ZERO) begin
         next_zq_cnt = zq_cnt - CNT_ONE;
         if (zq_cnt == CNT_ONE) begin
            if (ZQ_SELFTEST_EN) begin
               next_zq_result = zq_mapped;
            end
            if (ZQ_SELFTEST_EN && (zq_mapped != ZQ_PASS)) begin
               next_factory_trim_active = 1'b1;
            end else begin
               next_calib_apply = 1'b1;
            end
         end
      end
      // Only the feature register is writable here; the information one is not
      if (is_mrw && (ca_s.addr == MR_FEAT_ADDR)) begin
         next_feat = ca_s.data;
      end
   end

   // Registers only; the counter presets are parameters, hence constants
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_cnt <= 16'(INIT_CYCLES);
         zq_cnt <= CNT_ZERO;
         zq_result <= ZQ_NOT_SUPPORTED;
         factory_trim_active <= 1'b0;
         calib_apply <= 1'b0;
         feat <= FEAT_RESET;
      end else begin
         init_cnt <= next_init_cnt;
         zq_cnt <= next_zq_cnt;
         zq_result <= next_zq_result;
         factory_trim_active <= next_factory_trim_active;
         calib_apply <= next_calib_apply;
         feat <= next_feat;
      end
   end

   // ==========================================================
   // Information register and mode register read answer
   always_comb begin
      info = 8'h00;
      info[INFO_INIT_BIT] = (init_cnt != CNT_ZERO);
      info[INFO_CLASS_BIT] = INFO_CLASS_VALUE;
      info[INFO_DNV_BIT] = INFO_DNV_VALUE;
      info[INFO_ZQ_LSB +: 2] = zq_result;
   end

   logic [7:0] next_mr_rd_data;
   logic next_mr_rd_valid;

   // Write-only and reserved addresses answer zero rather than noise
   always_comb begin
      next_mr_rd_data = mr_rd_data;
      next_mr_rd_valid = 1'b0;
      if (is_mrr) begin
         next_mr_rd_valid = 1'b1;
         next_mr_rd_data = (ca_s.addr == MR_INFO_ADDR) ? info : 8'h00;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mr_rd_data <= 8'h00;
         mr_rd_valid <= 1'b0;
      end else begin
         mr_rd_data <= next_mr_rd_data;
         mr_rd_valid <= next_mr_rd_valid;
      end
   end

   // ==========================================================
   // Burst sequencing; a burst command while one runs is dropped
   logic seq_busy, seq_last, seq_start;
   logic burst_write, next_burst_write, burst_ap, next_burst_ap;
   logic next_beat_is_write;

   assign seq_start = is_burst && !seq_busy;

   dmib_burst_seq #(
      .COL_W(9)
   ) u_seq (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(seq_start),
      .start_col({ca_s.col, 1'b0}),
      .len_code(feat[FEAT_BL_LSB +: 3]),
      .interleave(feat[FEAT_BT_BIT]),
      .no_wrap(feat[FEAT_WC_BIT]),
      .beat_col(beat_col),
      .beat_valid(beat_valid),
      .beat_last(seq_last),
      .busy(seq_busy)
   );

   // Remember direction and auto-precharge of the running burst
   always_comb begin
      next_burst_write = burst_write;
      next_burst_ap = burst_ap;
      next_beat_is_write = burst_write;
      if (seq_start) begin
         next_burst_write = (ca_s.cmd == DMIB_CMD_WRITE);
         next_burst_ap = ca_s.auto_pre;
         next_beat_is_write = (ca_s.cmd == DMIB_CMD_WRITE);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         burst_write <= 1'b0;
         burst_ap <= 1'b0;
         beat_is_write <= 1'b0;
      end else begin
         burst_write <= next_burst_write;
         burst_ap <= next_burst_ap;
         beat_is_write <= next_beat_is_write;
      end
   end

   // ==========================================================
   // Write recovery: count link clock cycles after a write burst with AP
   dmib_pre_state_t pre_state, next_pre_state;
   logic [3:0] wr_cnt, next_wr_cnt;
   logic next_auto_precharge_start;

   always_comb begin
      next_pre_state = pre_state;
      next_wr_cnt = wr_cnt;
      next_auto_precharge_start = 1'b0;
      unique case (pre_state)
         DMIB_PRE_IDLE: begin
            if (seq_last && burst_write && burst_ap) begin
               next_pre_state = DMIB_PRE_WAIT;
               next_wr_cnt = {1'b0, feat[FEAT_WR_LSB +: 3]} + WR_CODE_OFFSET;
            end
         end
         DMIB_PRE_WAIT: begin
            if (link_rise) begin
               next_wr_cnt = wr_cnt - 4'h1;
               if (wr_cnt == 4'h1) begin
                  next_auto_precharge_start = 1'b1;
                  next_pre_state = DMIB_PRE_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_state <= DMIB_PRE_IDLE;
         wr_cnt <= 4'h0;
         auto_precharge_start <= 1'b0;
      end else begin
         pre_state <= next_pre_state;
         wr_cnt <= next_wr_cnt;
         auto_precharge_start <= next_auto_precharge_start;
      end
   end
endmodule
`default_nettype wire

// >>> verif/dmib_checker.sv
/*
 * Port checker for dmib_top: mode register answers, burst column order,
 * self-test outcome and write-recovery timing.
 * Assumes one core clock and an active-high asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module dmib_checker #(
   parameter int INIT_CYCLES = 64
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Watched outputs
   input wire logic [7:0] mr_rd_data,
   input wire logic mr_rd_valid,
   input wire logic [8:0] beat_col,
   input wire logic beat_valid,
   input wire logic auto_precharge_start,
   input wire logic factory_trim_active,
   input wire logic calib_apply
);
   logic [15:0] up_cnt;
   logic [15:0] next_up_cnt;
   logic [7:0] idle_cnt;
   logic [7:0] next_idle_cnt;
   // ====================
   // Cycles since release and since the last beat; saturate so they never wrap
   always_comb begin
      next_up_cnt = (&up_cnt) ? up_cnt : up_cnt + 16'h0001;
      next_idle_cnt = beat_valid ? 8'h00 : ((&idle_cnt) ? idle_cnt : idle_cnt + 8'h01);
   end
   // Registers of the helper counters
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_cnt <= 16'h0000;
         idle_cnt <= 8'h00;
      end else begin
         up_cnt <= next_up_cnt;
         idle_cnt <= next_idle_cnt;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ====================
   // Properties; the init window keeps two cycles of slack for the answer latency
   a_init_busy_early: assert property (mr_rd_valid && up_cnt < INIT_CYCLES - 2 |-> mr_rd_data[0])
      else $error("init flag low too early");
   a_init_done_late: assert property (mr_rd_valid && up_cnt > INIT_CYCLES + 2 |-> !mr_rd_data[0])
      else $error("init flag still high");
   a_fixed_bits_zero: assert property (mr_rd_valid |-> mr_rd_data[2:1] == 2'h0)
      else $error("class or invalid-data bit set");
   a_reserved_zero: assert property (mr_rd_valid |-> mr_rd_data[7:5] == 3'h0)
      else $error("reserved bits not zero");
   a_trim_sticky: assert property (factory_trim_active |=> factory_trim_active)
      else $error("factory trim dropped");
   a_trim_no_apply: assert property (factory_trim_active |-> !calib_apply)
      else $error("calibration applied under fault");
   a_first_beat_even: assert property ($rose(beat_valid) |-> !beat_col[0])
      else $error("burst starts on odd column");
   a_beat_alternates: assert property (beat_valid ##1 beat_valid |-> beat_col[0] != $past(beat_col[0]))
      else $error("column bit0 did not alternate");
   a_pair_upper_held: assert property (beat_valid && beat_col[0] |->
      $past(beat_valid) && beat_col[8:1] == $past(beat_col[8:1]))
      else $error("odd beat not paired with even beat");
   a_recovery_window: assert property (auto_precharge_start |-> idle_cnt >= 8'h10 && idle_cnt <= 8'h50)
      else $error("precharge outside recovery window");
endmodule
bind dmib_top dmib_checker #(.INIT_CYCLES(INIT_CYCLES)) u_checker (
   .ref_clk(ref_clk),
   .rst(rst),
   .mr_rd_data(mr_rd_data),
   .mr_rd_valid(mr_rd_valid),
   .beat_col(beat_col),
   .beat_valid(beat_valid),
   .auto_precharge_start(auto_precharge_start),
   .factory_trim_active(factory_trim_active),
   .calib_apply(calib_apply)
);
`default_nettype wire

// >>> verif/dmib_ctrl_model.sv
/*
 * Memory controller model: free-running link clock and command words.
 * Assumes callers let each task return before issuing the next one.
 */
`timescale 1ns/100ps
`default_nettype none
module dmib_ctrl_model (
   // Link pins toward the device
   output logic link_clk,
   output var dmib_pkg::dmib_ca_word_t ca_pins
);
   import dmib_pkg::*;
   logic [2:0] f_code;
   logic f_wc;
   // ====================
   // Memory clock runs free; its phase is unrelated to the core clock
   initial begin
      link_clk = 1'b0;
      ca_pins = '0;
      f_code = 3'h2;
      f_wc = 1'b0;
      #1.3;
      forever #16 link_clk = ~link_clk;
   end
   // Word changes on the falling edge so it is steady around the rising one
   task automatic send(input dmib_ca_word_t w);
      @(negedge link_clk);
      ca_pins <= w;
      @(negedge link_clk);
      ca_pins <= ~w & 28'h1ffffff;
   endtask
   // Register write; unused bits go out as zero
   task automatic mrw(input logic [7:0] a, input logic [7:0] d);
      send('{cmd: DMIB_CMD_MRW, auto_pre: 1'b0, addr: a, data: d, col: 8'h00});
   endtask
   // Register read
   task automatic read_reg(input logic [7:0] a);
      send('{cmd: DMIB_CMD_MRR, auto_pre: 1'b0, addr: a, data: 8'h00, col: 8'h00});
   endtask
   // Only legal lengths and order/wrap pairings leave the controller
   task automatic feature(input logic [2:0] code, input logic bt, input logic wc, input logic [2:0] write_recovery_cycles);
      f_code = (code == 3'h3 || code == 3'h4) ? code : 3'h2;
      f_wc = wc & (f_code == 3'h2);
      mrw(MR_FEAT_ADDR, {write_recovery_cycles, f_wc, bt & (f_code != 3'h4), f_code});
   endtask
   // Column bit 0 has no pin; no-wrap starts stay clear of the page end
   task automatic burst(input logic wr, input logic [8:1] c);
      logic [8:1] s;
      s = (f_wc && (c == 8'hff || c == 8'h00)) ? 8'h01 : c;
      send('{cmd: wr ? DMIB_CMD_WRITE : DMIB_CMD_READ, auto_pre: 1'b1, addr: 8'h00, data: 8'h00, col: s});
   endtask
endmodule
`default_nettype wire

// >>> verif/dmib_top_tb.sv
/*
 * Self-checking bench for dmib_top: the controller model drives the link
 * pins, expectations for info reads, burst order and recovery are computed.
 * Assumes the checker is bound to the device by its own file.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dmib_top_tb;
   import dmib_pkg::*;
   localparam logic [4:0] CFGS [6] = '{5'h08, 5'h0a, 5'h09, 5'h0c, 5'h0e, 5'h10};
   logic ref_clk, rst, link_clk, mr_rd_valid, beat_valid, beat_is_write;
   logic auto_precharge_start, factory_trim_active, calib_apply;
   logic [1:0] zq_sense;
   logic [2:0] lk;
   logic [7:0] mr_rd_data, rd_data;
   logic [8:0] beat_col;
   logic [8:0] beats [$];
   dmib_ca_word_t ca_pins;
   int rd_cnt, bcnt, pre_cnt, edges, pre_edges, apply_cnt, num_errors, n_compared;
   dmib_ctrl_model u_ctrl (.link_clk(link_clk), .ca_pins(ca_pins));
   dmib_top #(.INIT_CYCLES(40), .ZQ_CAL_CYCLES(2), .ZQ_SELFTEST_EN(1'b1)) dut (
      .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .ca_pins(ca_pins), .zq_sense(zq_sense),
      .mr_rd_data(mr_rd_data), .mr_rd_valid(mr_rd_valid), .beat_col(beat_col), .beat_valid(beat_valid),
      .beat_is_write(beat_is_write), .auto_precharge_start(auto_precharge_start),
      .factory_trim_active(factory_trim_active), .calib_apply(calib_apply));
   // ====================
   // Core clock, 250 MHz
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Capture; link edges are re-synchronised the way the device sees them
   always @(posedge ref_clk) begin
      lk <= {lk[1:0], link_clk};
      // The device counts link edges from the cycle right after the last beat
      edges <= beat_valid ? 0 : edges + int'(lk[1] && !lk[2]);
      if (beat_valid === 1'b1) begin
         beats.push_back(beat_col);
         bcnt <= bcnt + 1;
      end
      if (mr_rd_valid === 1'b1) begin
         rd_data <= mr_rd_data;
         rd_cnt <= rd_cnt + 1;
      end
      if (auto_precharge_start === 1'b1) begin
         pre_edges <= edges;
         pre_cnt <= pre_cnt + 1;
      end
      if (calib_apply === 1'b1) apply_cnt <= apply_cnt + 1;
   end
   // ====================
   // Expected self-test code per pin condition: 0 resistor, 2 ground, else supply.
   // A pass code is taken only as proof that a resistor is present, not its value
   function automatic logic [1:0] zq_exp(int s);
      return (s == 0) ? ZQ_PASS : ((s == 2) ? ZQ_SHORT_GND : ZQ_TIED_SUPPLY);
   endfunction
   // Expected column of beat i; cfg is {length code, interleave, no-wrap}
   function automatic logic [8:0] exp_col(logic [8:0] b, logic [4:0] cfg, int i);
      logic [8:0] m;
      m = (cfg[4:2] == 3'h4) ? 9'h00f : ((cfg[4:2] == 3'h3) ? 9'h007 : 9'h003);
      if (cfg[0]) return b + 9'(i);
      if (cfg[1]) return (b & ~m) | ((b ^ 9'(i)) & m);
      return (b & ~m) | ((b + 9'(i)) & m);
   endfunction
   task automatic end_of_test();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Bounded wait on a capture counter; running out ends the run
   task automatic wait_cnt(ref int c, input int goal);
      for (int k = 0; k < 300 && c < goal; k++) @(posedge ref_clk);
      if (c < goal) begin
         `CHK(c, goal)
         end_of_test();
      end
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic check_info(input logic [7:0] exp);
      int c0;
      c0 = rd_cnt;
      u_ctrl.read_reg(MR_INFO_ADDR);
      wait_cnt(rd_cnt, c0 + 1);
      `CHK(rd_data, exp)
   endtask
   // Calibration lasts a few core cycles; eight covers the link latency too
   task automatic calibrate();
      u_ctrl.mrw(MR_CALIB_ADDR, 8'h00);
      repeat (8) @(posedge ref_clk);
   endtask
   // ====================
   // Main sequence
   initial begin
      logic [4:0] cfg;
      logic [2:0] write_recovery_cycles;
      logic [8:0] col;
      logic wr;
      int a0, p0, b0, blen;
      rst = 1'b1;
      zq_sense = 2'h0;
      void'($urandom(32'hd8d9a855));
      @(posedge ref_clk);
      // Every pin condition from a fresh reset, since a fault locks until reset
      for (int s = 0; s < 4; s++) begin
         zq_sense <= 2'(s);
         do_reset();
         check_info(8'h01);
         u_ctrl.mrw(MR_INFO_ADDR, 8'hff);
         repeat (40) @(posedge ref_clk);
         check_info(8'h00);
         a0 = apply_cnt;
         calibrate();
         check_info({3'h0, zq_exp(s), 3'h0});
         `CHK(factory_trim_active, 1'(zq_exp(s) != ZQ_PASS))
         `CHK(apply_cnt - a0, (zq_exp(s) == ZQ_PASS) ? 1 : 0)
         zq_sense <= 2'h0;
         calibrate();
         check_info({3'h0, zq_exp(s), 3'h0});
         `CHK(apply_cnt - a0, (zq_exp(s) == ZQ_PASS) ? 2 : 0)
      end
      // A read of the write-only feature register answers zero
      a0 = rd_cnt;
      u_ctrl.read_reg(MR_FEAT_ADDR);
      wait_cnt(rd_cnt, a0 + 1);
      `CHK(rd_data, 8'h00)
      // Every legal length/order/wrap setting except interleaved no-wrap, random start and recovery
      for (int i = 0; i < 18; i++) begin
         cfg = CFGS[i % 6];
         write_recovery_cycles = 3'($urandom_range(6, 1));
         col = (i == 0) ? 9'h1fe : {8'($urandom_range(254, 1)), 1'b0};
         wr = (i < 6) ? 1'b1 : 1'($urandom_range(1, 0));
         u_ctrl.feature(cfg[4:2], cfg[1], cfg[0], write_recovery_cycles);
         blen = 1 << cfg[4:2];
         b0 = bcnt;
         p0 = pre_cnt;
         beats.delete();
         u_ctrl.burst(wr, col[8:1]);
         wait_cnt(bcnt, b0 + blen);
         `CHK(beat_is_write, wr)
         for (int k = 0; k < blen; k++) `CHK(beats[k], exp_col(col, cfg, k))
         if (wr) begin
            wait_cnt(pre_cnt, p0 + 1);
            `CHK(pre_edges, int'(write_recovery_cycles) + 2)
         end
      end
      end_of_test();
   end
endmodule
`default_nettype wire
